// [pkg/tmc_regs.svh]
// Register offsets, field positions, reset values and timing counts of the timer/counter.
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
`define TMC_OFF_COUNT      12'h000
`define TMC_OFF_OPTION     12'h004
`define TMC_OFF_INTCTL     12'h008
`define TMC_OFF_STATUS     12'h00c
`define TMC_OFF_CLEAR      12'h010
`define TMC_OFF_ENABLE     12'h014
`define TMC_OPT_PS_LSB     0
`define TMC_OPT_PSA        3
`define TMC_OPT_SE         4
`define TMC_OPT_CS         5
`define TMC_INT_FLAG       2
`define TMC_INT_IE         5
`define TMC_OPT_RESET      8'hff
`define TMC_INT_RESET      8'h00
`define TMC_CLK_MHZ        125
`define TMC_ICLK_MHZ       2
`define TMC_ICLK_DIV       ((`TMC_CLK_MHZ + `TMC_ICLK_MHZ - 1) / `TMC_ICLK_MHZ)
`define TMC_INHIBIT_CYC    2
`endif

// [pkg/tmc_pkg.sv]
// Types shared by the timer/counter design.
`default_nettype none
package tmc_pkg;
   typedef enum logic [1:0] {
      TMC_Q1 = 2'b00,
      TMC_Q2 = 2'b01,
      TMC_Q3 = 2'b10,
      TMC_Q4 = 2'b11
   } tmc_phase_t;
   typedef struct packed {
      logic [7:0]  count;
      logic [7:0]  option;
      logic        flag;
      logic        irq_en;
      logic [7:0]  presc;
      logic [1:0]  inhibit;
      logic [6:0]  div;
      tmc_phase_t  phase;
      logic        ext_d;
      logic        ext_sync;
      logic        prs_q2;
      logic        prs_out_d;
      logic        ovf_sts;
      logic        ovf_en;
      logic [31:0] prdata;
      logic        pready;
      logic        irq;
   } tmc_state_t;
endpackage
`default_nettype wire

// [core/tmc_timer0.sv]
// Eight-bit timer/counter with shared prescaler behind an APB slave.
//
// Operation
// RQ1: Eight-bit counter with eight-bit prescaler, timer/counter.
// RQ2: Timer mode increments every instruction cycle.
// RQ3: Counter write blocks increments two cycles.
// RQ4: Counter mode counts selected edge of input.
// RQ5: Counter mode selected by writing one.
// RQ6: Assign bit zero gives prescaler to counter.
// RQ7: Rate field picks 1:2 to 1:256.
// RQ8: Assign bit set bypasses prescaler, 1:1.
// RQ9: Prescaler hidden; counter write clears it.
// RQ10: Software sequence moving prescaler to watchdog.
// RQ11: Software sequence moving prescaler to counter.
// RQ12: Wrap from maximum to zero sets flag.
// RQ13: Only software clears flag; enable gates request.
// RQ14: External path sampled on second, fourth phase.
// RQ15: Sleep stops counter, value kept.
// RQ16: Overflow never wakes from Sleep.
// RQ17: Instruction clock is 2 MHz; the code gives one icyc every 252 clocks, near 0.5 MHz.
// RQ18: Rate n divides by two to n+1.
`include "tmc_regs.svh"
`default_nettype none
module tmc_timer0 (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device context.
   input  wire logic        external_count_input,
   input  wire logic        sleep_mode,
   input  wire logic        watchdog_timer_clear,
   // Interrupt and prescaler output.
   output logic             irq,
   output logic             wdt_prescaler_tick
);
   import tmc_pkg::*;

   // ==========================================================
   // State registers
   tmc_state_t st_r;
   tmc_state_t st_nxt;
   logic       wdt_tick_r;
   logic       wdt_tick_nxt;

   logic wr_acc;
   logic rd_setup;
   logic wrap_ev;
   logic icyc;
   logic prescaler_assign;
   logic tmode;
   logic cnt_wr;
   logic presc_clk;
   logic ext_edge;
   logic prs_out;
   logic inc;
   logic [7:0] ps_mask;

   // Bus strobes; read data is registered in the setup cycle so it stands through the access cycle.
   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign cnt_wr = wr_acc && (paddr == `TMC_OFF_COUNT);
   assign prescaler_assign    = st_r.option[`TMC_OPT_PSA];
   assign tmode  = !st_r.option[`TMC_OPT_CS]; // [RQ2] [RQ5]
   // Instruction cycle pulse from the phase divider, last phase.
   assign icyc   = (st_r.div == 7'(`TMC_ICLK_DIV - 1)) && (st_r.phase == TMC_Q4); // [RQ17]

   // ==========================================================
   // Prescaler select
   // Tap bit n of the ripple prescaler gives 2^(n+1) division.
   always_comb begin
      ps_mask = 8'h00;
      ps_mask[st_r.option[2:0]] = 1'b1; // [RQ18] [RQ7]
   end

   // Edge of the selected source that feeds the prescaler.
   assign ext_edge  = st_r.option[`TMC_OPT_SE] ? (st_r.ext_d && !external_count_input)
                                             : (!st_r.ext_d && external_count_input); // [RQ4]
   assign presc_clk = tmode ? icyc : ext_edge;
   // Prescaler output level, or the per-edge toggle ext_sync when bypassed.
   assign prs_out   = prescaler_assign ? st_r.ext_sync : (|(st_r.presc & ps_mask)); // [RQ8]

   always_comb begin
      st_nxt       = st_r;
      wdt_tick_nxt = 1'b0;
      inc          = 1'b0;
      wrap_ev      = 1'b0;
      st_nxt.ext_d = external_count_input;
      // Phase divider for the instruction clock.
      if (st_r.div == 7'(`TMC_ICLK_DIV - 1)) begin
         st_nxt.div   = 7'h00;
         st_nxt.phase = tmc_phase_t'(2'(st_r.phase + 2'h1));
      end else begin
         st_nxt.div = 7'(st_r.div + 7'h01);
      end
      // Shared prescaler; only one owner at a time.
      if (!prescaler_assign) begin // [RQ6]
         if (presc_clk && !sleep_mode) begin
            st_nxt.presc = 8'(st_r.presc + 8'h01); // [RQ1]
         end
      end else if (watchdog_timer_clear) begin
         st_nxt.presc = 8'h00;
      end else if (st_r.div == 7'h00 && st_r.phase == TMC_Q1) begin
         st_nxt.presc = 8'(st_r.presc + 8'h01);
         // One tick each time the selected tap rises, once per full division.
         wdt_tick_nxt = |(8'(st_r.presc + 8'h01) & ~st_r.presc & ps_mask);
      end
      // External edge held for resync when bypassing the prescaler.
      if (ext_edge) begin
         st_nxt.ext_sync = ~st_r.ext_sync;
      end
      // Sample prescaler output on Q2 then Q4 into the counter domain.
      if (st_r.div == 7'h00 && st_r.phase == TMC_Q2) begin
         st_nxt.prs_q2 = tmode && prescaler_assign ? st_r.prs_q2 : prs_out; // [RQ14]
      end
      if (st_r.div == 7'h00 && st_r.phase == TMC_Q4) begin
         st_nxt.prs_out_d = st_r.prs_q2; // [RQ14]
         if (!tmode || !prescaler_assign) begin
            inc = st_r.prs_q2 && !st_r.prs_out_d;
         end
      end
      if (tmode && prescaler_assign) begin
         inc = icyc; // [RQ2]
      end
      // Bypassed external path toggles once per edge, so either change counts.
      if (!tmode && prescaler_assign) begin
         inc = (st_r.div == 7'h00 && st_r.phase == TMC_Q4) && (st_r.prs_q2 != st_r.prs_out_d); // [RQ4]
      end
      // Write inhibit counts down in instruction cycles.
      if (icyc && st_r.inhibit != 2'h0) begin
         st_nxt.inhibit = 2'(st_r.inhibit - 2'h1);
      end
      // Counter increment, frozen in Sleep.
      if (inc && !sleep_mode && st_r.inhibit == 2'h0) begin // [RQ15] [RQ3]
         st_nxt.count = 8'(st_r.count + 8'h01);
         if (st_r.count == 8'hff) begin
            wrap_ev        = 1'b1;
            st_nxt.flag    = 1'b1; // [RQ12]
            st_nxt.ovf_sts = 1'b1;
         end
      end
      // Register writes; hardware set wins over software clear.
      if (wr_acc) begin
         case (paddr)
            `TMC_OFF_COUNT: begin
               st_nxt.count   = pwdata[7:0];
               st_nxt.inhibit = 2'(`TMC_INHIBIT_CYC); // [RQ3]
               if (!prescaler_assign) begin
                  st_nxt.presc = 8'h00; // [RQ9]
               end
            end
            `TMC_OFF_OPTION: st_nxt.option = pwdata[7:0];
            `TMC_OFF_INTCTL: begin
               st_nxt.irq_en = pwdata[`TMC_INT_IE];
               st_nxt.flag   = pwdata[`TMC_INT_FLAG] || wrap_ev; // [RQ13]
            end
            `TMC_OFF_CLEAR: begin
               if (pwdata[0] && !wrap_ev) begin
                  st_nxt.ovf_sts = 1'b0;
               end
            end
            `TMC_OFF_ENABLE: st_nxt.ovf_en = pwdata[0];
            default: begin
            end
         endcase
      end
      // Read mux; the prescaler count is never visible.
      st_nxt.prdata = 32'h0000_0000;
      if (rd_setup) begin
         case (paddr)
            `TMC_OFF_COUNT:  st_nxt.prdata = {24'h000000, st_r.count};
            `TMC_OFF_OPTION: st_nxt.prdata = {24'h000000, st_r.option};
            `TMC_OFF_INTCTL: st_nxt.prdata = {26'h0, st_r.irq_en, 2'b00, st_r.flag, 2'b00};
            `TMC_OFF_STATUS: st_nxt.prdata = {31'h0, st_r.ovf_sts};
            `TMC_OFF_ENABLE: st_nxt.prdata = {31'h0, st_r.ovf_en};
            default:         st_nxt.prdata = 32'h0000_0000;
         endcase
      end
      // Ready stands in the access cycle that follows every setup cycle.
      st_nxt.pready = psel && !penable;
      // Interrupt request gated by enable; frozen counter cannot raise it in Sleep.
      st_nxt.irq = (st_nxt.flag && st_nxt.irq_en) || (st_nxt.ovf_sts && st_nxt.ovf_en); // [RQ13] [RQ16]
   end

   // Register the whole state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= '0;
         st_r.option <= `TMC_OPT_RESET;
         st_r.phase  <= TMC_Q1;
         wdt_tick_r  <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         wdt_tick_r <= wdt_tick_nxt;
      end
   end

   // Outputs.
   assign prdata             = st_r.prdata;
   assign pready             = st_r.pready;
   assign pslverr            = 1'b0;
   assign irq                = st_r.irq;
   assign wdt_prescaler_tick = wdt_tick_r;

   // ==========================================================
   // Assertions
   sequence count_write_s;
      cnt_wr ##1 1'b1;
   endsequence

   sequence flag_set_s;
      $rose(st_r.flag);
   endsequence

   inhibit_after_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
      count_write_s |-> st_r.inhibit == 2'h2)
      else $error("inhibit not loaded after counter write");
   no_inc_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
      (st_r.inhibit != 2'h0 && !wr_acc) |=> st_r.count == $past(st_r.count))
      else $error("counter moved while inhibited");
   sleep_freeze_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
      (sleep_mode && !wr_acc) |=> st_r.count == $past(st_r.count))
      else $error("counter moved in sleep");
   wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
      (st_r.count == 8'hff && !wr_acc) ##1 (st_r.count == 8'h00) |-> st_r.flag)
      else $error("wrap did not set flag");
   flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
      (st_r.flag && !(wr_acc && paddr == `TMC_OFF_INTCTL)) |=> st_r.flag)
      else $error("flag cleared by hardware");
   presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
      (cnt_wr && !prescaler_assign) |=> st_r.presc == 8'h00)
      else $error("prescaler not cleared by counter write");
   irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
      (!st_r.irq_en && !st_r.ovf_en) ##1 (!st_r.irq_en && !st_r.ovf_en) |-> !irq)
      else $error("irq raised while disabled");
   timer_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
      (tmode && prescaler_assign && icyc && st_r.inhibit == 2'h0 && !sleep_mode && !wr_acc)
      |=> st_r.count == 8'($past(st_r.count) + 8'h01))
      else $error("timer did not step on instruction cycle");
   flag_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
      flag_set_s ##0 st_r.irq_en |-> irq)
      else $error("enabled flag gave no irq");

   // The watchdog sees no tick while the counter owns the prescaler.
   tick_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
      !prescaler_assign |=> !wdt_prescaler_tick)
      else $error("watchdog tick while prescaler on counter");

   // Under the watchdog the prescaler moves only once per instruction cycle.
   presc_hold_wdt_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
      (prescaler_assign && !watchdog_timer_clear && !(st_r.div == 7'h00 && st_r.phase == TMC_Q1)) |=> $stable(st_r.presc))
      else $error("watchdog prescaler moved off its step");

   // A watchdog clear empties the prescaler it owns.
   presc_wdt_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
      (prescaler_assign && watchdog_timer_clear) |=> st_r.presc == 8'h00)
      else $error("watchdog clear left prescaler");

   // Sleep holds the counter's prescaler as well.
   sleep_presc_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
      (sleep_mode && !prescaler_assign && !cnt_wr) |=> $stable(st_r.presc))
      else $error("prescaler moved in sleep");

   // The first sampling stage changes only on the second phase.
   q2_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
      !(st_r.div == 7'h00 && st_r.phase == TMC_Q2) |=> $stable(st_r.prs_q2))
      else $error("sample moved outside second phase");

   // The second sampling stage changes only on the fourth phase.
   q4_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
      !(st_r.div == 7'h00 && st_r.phase == TMC_Q4) |=> $stable(st_r.prs_out_d))
      else $error("sample moved outside fourth phase");

   // Status stays set until software clears it.
   ovf_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
      (st_r.ovf_sts && !(wr_acc && paddr == `TMC_OFF_CLEAR)) |=> st_r.ovf_sts)
      else $error("status cleared by hardware");

   // A wrap sets flag and status even against a clear in the same cycle.
   wrap_status_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
      wrap_ev |=> st_r.ovf_sts && st_r.flag)
      else $error("wrap lost against clear");

   // Status rises only from a wrap of the counter.
   ovf_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
      $rose(st_r.ovf_sts) |-> $past(st_r.count) == 8'hff)
      else $error("status set without wrap");

   // A counter write lands with the written byte.
   write_lands_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
      cnt_wr |=> st_r.count == $past(pwdata[7:0]))
      else $error("counter write lost");

   // An option write lands with the written byte.
   option_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
      (wr_acc && paddr == `TMC_OFF_OPTION) |=> st_r.option == $past(pwdata[7:0]))
      else $error("option write lost");

   // Exactly one prescaler tap is selected.
   rate_tap_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ18]
      $onehot(ps_mask))
      else $error("prescaler tap not one-hot");

   // The hold-off counts down once per instruction cycle.
   inhibit_count_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
      (st_r.inhibit != 2'h0 && icyc && !cnt_wr) |=> st_r.inhibit == 2'($past(st_r.inhibit) - 2'h1))
      else $error("hold-off did not count down");

   // No flag can rise while asleep, so nothing wakes the core.
   no_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
      (sleep_mode && !wr_acc) |=> !$rose(st_r.flag))
      else $error("flag rose in sleep");

   // Every setup cycle is answered in the next cycle.
   ready_setup_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
      (psel && !penable) |=> pready)
      else $error("no ready in access cycle");

   // Counter reads return the count seen in the setup cycle.
   read_data_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
      (rd_setup && paddr == `TMC_OFF_COUNT) |=> prdata == {24'h000000, $past(st_r.count)})
      else $error("counter read data wrong");

   // The request level follows the enabled sticky bits.
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
      irq == ((st_r.flag && st_r.irq_en) || (st_r.ovf_sts && st_r.ovf_en)))
      else $error("irq level wrong");

   // The phase divider starts a new instruction cycle after the last phase.
   phase_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
      icyc |=> st_r.phase == TMC_Q1 && st_r.div == 7'h00)
      else $error("phase divider out of step");

   // Without a write the counter moves by at most one per clock.
   inc_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
      !wr_acc |=> (st_r.count == $past(st_r.count) || st_r.count == 8'($past(st_r.count) + 8'h01)))
      else $error("counter jumped");
endmodule // tmc_timer0
`default_nettype wire

// [testbench/tmc_edge_src.sv]
// Behavioural source of edges on the external count input.
`default_nettype none
module tmc_edge_src (
   // Clock.
   input  wire logic pclk,
   // Count pin, pulled low when idle.
   output logic      pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Pulse train
   // Each level lasts longer than an instruction cycle so both phases see it.
   task automatic pulses(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         pin <= 1'b1;
         repeat (half) @(posedge pclk);
         pin <= 1'b0;
         repeat (half) @(posedge pclk);
      end
   endtask
   // The pin idles low between trains.
   initial pin = 1'b0;
endmodule // tmc_edge_src
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the timer/counter over APB.
`include "tmc_regs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, sleep_mode, wdt_clr;
   logic        pready, pslverr, irq, ext_in, wdt_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  v, u;
   int          errors, checked, cyc, w, t1, t2, p1, ticks;

   // ==========
   // Clock, cycle count and instances
   // The clock toggles every 4 ns, a period of 8 ns.
   always #4 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   // Counts the ticks handed to the watchdog.
   always @(posedge pclk) if (wdt_tick === 1'b1) ticks <= ticks + 1;
   tmc_timer0 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_count_input(ext_in), .sleep_mode(sleep_mode), .watchdog_timer_clear(wdt_clr),
      .irq(irq), .wdt_prescaler_tick(wdt_tick));
   tmc_edge_src src (.pclk(pclk), .pin(ext_in));

   // ==========
   // Tasks
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One APB transfer: setup, then access held until pready is sampled high at a rising edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      if (pready !== 1'b1) begin
         errors++;
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      d = r[7:0];
   endtask
   // Polls the count until it moves; stamps the cycle and keeps the new value.
   task automatic nxt(output int t);
      logic [7:0] a, b;
      int         n;
      rd(`TMC_OFF_COUNT, a);
      n = 0;
      do begin
         rd(`TMC_OFF_COUNT, b);
         n++;
      end while (b === a && n < 4000);
      if (n >= 4000) begin
         errors++;
         stop_test();
      end
      t = cyc;
      v = b;
   endtask
   // One-cycle watchdog clear pulse.
   task automatic clr_wdt;
      wdt_clr <= 1'b1;
      @(posedge pclk);
      wdt_clr <= 1'b0;
   endtask

   // ==========
   // Main sequence
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      sleep_mode = 0; wdt_clr = 0; errors = 0; checked = 0; cyc = 0; ticks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`TMC_OFF_OPTION, v);
      chk(v, `TMC_OPT_RESET, "option reset");
      apb(1'b0, 12'h020, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      // Timer mode without prescaler, and the hold-off after a write.
      wr(`TMC_OFF_OPTION, 8'h08);
      wr(`TMC_OFF_COUNT, 8'h10);
      w = cyc;
      nxt(t1);
      chk(v, 8'h11, "first step");
      nxt(t2);
      chk(v, 8'h12, "second step");
      p1 = t2 - t1;
      chk(t1 - w > 2 * p1 - 8 && t1 - w < 3 * p1 + 8, 1, "hold-off after write");
      // Prescaler on the counter at 1:2 and 1:4.
      for (int r = 0; r < 2; r++) begin
         wr(`TMC_OFF_OPTION, 8'(r));
         wr(`TMC_OFF_COUNT, 8'h00);
         nxt(t1);
         nxt(t2);
         chk((t2 - t1) > (2 << r) * p1 - 8 && (t2 - t1) < (2 << r) * p1 + 8, 1, "rate");
      end
      // Wrap sets both flags; clears are separate.
      wr(`TMC_OFF_OPTION, 8'h08);
      wr(`TMC_OFF_ENABLE, 8'h01);
      wr(`TMC_OFF_COUNT, 8'hfe);
      nxt(t1);
      nxt(t2);
      chk(v, 8'h00, "wrap");
      rd(`TMC_OFF_INTCTL, v);
      chk(v[2], 1'b1, "flag set");
      rd(`TMC_OFF_STATUS, v);
      chk(v[0], 1'b1, "status set");
      chk(irq, 1'b1, "irq raised");
      wr(`TMC_OFF_CLEAR, 8'h01);
      rd(`TMC_OFF_STATUS, v);
      chk(v[0], 1'b0, "status cleared");
      chk(irq, 1'b0, "irq dropped");
      rd(`TMC_OFF_INTCTL, v);
      chk(v[2], 1'b1, "flag kept");
      wr(`TMC_OFF_INTCTL, 8'h20);
      rd(`TMC_OFF_INTCTL, v);
      chk(v, 8'h20, "flag cleared");
      // Sleep freezes the count.
      sleep_mode <= 1'b1;
      rd(`TMC_OFF_COUNT, v);
      repeat (3 * p1) @(posedge pclk);
      rd(`TMC_OFF_COUNT, u);
      chk(u, v, "frozen");
      chk(irq, 1'b0, "no wake");
      sleep_mode <= 1'b0;
      // Counter mode on rising, then on falling edges.
      for (int e = 0; e < 2; e++) begin
         wr(`TMC_OFF_OPTION, e ? 8'h38 : 8'h28);
         wr(`TMC_OFF_COUNT, 8'h00);
         repeat (3 * p1) @(posedge pclk);
         src.pulses(5 - 2 * e, 300);
         repeat (400) @(posedge pclk);
         rd(`TMC_OFF_COUNT, v);
         chk(v, 8'(5 - 2 * e), "edge count");
      end
      // Hand the prescaler to the watchdog, then back to the counter.
      wr(`TMC_OFF_OPTION, 8'h00);
      clr_wdt();
      wr(`TMC_OFF_COUNT, 8'h00);
      wr(`TMC_OFF_OPTION, 8'h08);
      clr_wdt();
      wr(`TMC_OFF_OPTION, 8'h09);
      w = ticks;
      repeat (16 * p1) @(posedge pclk);
      chk(ticks - w >= 3 && ticks - w <= 5, 1, "watchdog ticks");
      clr_wdt();
      wr(`TMC_OFF_OPTION, 8'h01);
      w = ticks;
      wr(`TMC_OFF_COUNT, 8'h00);
      nxt(t1);
      nxt(t2);
      chk((t2 - t1) > 4 * p1 - 8 && (t2 - t1) < 4 * p1 + 8, 1, "rate after return");
      chk(ticks - w, 0, "watchdog quiet");
      stop_test();
   end
endmodule // tb
`default_nettype wire
